/* logic/rtcct_map.svh */
`ifndef RTCCT_MAP_SVH
`define RTCCT_MAP_SVH

// Register offsets
`define RTCCT_ADDR_FIRST_CONTROL 6'h00
`define RTCCT_ADDR_IRQ_CONTROL 6'h01
`define RTCCT_ADDR_IRQ_FLAGS 6'h02
`define RTCCT_ADDR_VALUE_LOW 6'h18
`define RTCCT_ADDR_VALUE_HIGH 6'h19

// First control fields
`define RTCCT_BIT_RUN_ENABLE 1
`define RTCCT_BIT_AUTO_RELOAD 2
`define RTCCT_BIT_RATE_LO 5
`define RTCCT_BIT_RATE_HI 6

// Interrupt control and flag fields
`define RTCCT_BIT_IRQ_ENABLE 1
`define RTCCT_BIT_DONE_FLAG 1

// Reset values
`define RTCCT_FIRST_CONTROL_RESET 8'h99
`define RTCCT_IRQ_CONTROL_RESET 1'b0
`define RTCCT_DONE_FLAG_RESET 1'b0
`define RTCCT_VALUE_RESET 16'h0000

// Timing: 32 Hz base tick from the system clock
`define RTCCT_CLK_HZ 50000000
`define RTCCT_BASE_HZ 32
`define RTCCT_BASE_DIV_CYCLES (`RTCCT_CLK_HZ / `RTCCT_BASE_HZ)

`endif

/* logic/rtcct_pkg.sv */
package rtcct_pkg;

  // Timer sequencing states
  typedef enum logic [3:0] {
    RTCCT_ST_IDLE = 4'h1,
    RTCCT_ST_RUN = 4'h2,
    RTCCT_ST_RELOAD = 4'h4,
    RTCCT_ST_DONE = 4'h8
  } rtcct_state_t;

  // Source clock rate selection
  typedef enum logic [1:0] {
    RTCCT_RATE_32HZ = 2'h0,
    RTCCT_RATE_8HZ = 2'h1,
    RTCCT_RATE_1HZ = 2'h2,
    RTCCT_RATE_HALF_HZ = 2'h3
  } rtcct_rate_t;

endpackage : rtcct_pkg

/* logic/rtcct_rate_div.sv */
`timescale 1ns/1ps
`include "rtcct_map.svh"

module rtcct_rate_div #(
  parameter int unsigned BASE_DIV = `RTCCT_BASE_DIV_CYCLES
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire rtcct_pkg::rtcct_rate_t rate_sel,
  output logic source_tick
);

  logic [20:0] base_cnt;
  logic [5:0] pre_cnt;
  logic base_tick;

  // Picks the selected rate out of the prescaler phase
  function automatic logic rate_hit(input rtcct_pkg::rtcct_rate_t sel, input logic [5:0] pre);
    case (sel)
      rtcct_pkg::RTCCT_RATE_32HZ: rate_hit = 1'b1;
      rtcct_pkg::RTCCT_RATE_8HZ: rate_hit = (pre[1:0] == 2'h3);
      rtcct_pkg::RTCCT_RATE_1HZ: rate_hit = (pre[4:0] == 5'h1F);
      default: rate_hit = (pre == 6'h3F);
    endcase
  endfunction : rate_hit

  assign base_tick = (base_cnt == 21'(BASE_DIV - 1));

  // Free-running 32 Hz base; no restart, so the first tick has up to one period of jitter
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      base_cnt <= 21'h000000;
    end
    else if (base_tick)
    begin
      base_cnt <= 21'h000000;
    end
    else
    begin
      base_cnt <= base_cnt + 21'h000001;
    end
  end

  // Prescaler for the slower rates
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pre_cnt <= 6'h00;
    end
    else if (base_tick)
    begin
      pre_cnt <= pre_cnt + 6'h01;
    end
  end

  // One-cycle enable at the selected source rate
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      source_tick <= 1'b0;
    end
    else
    begin
      source_tick <= base_tick && rate_hit(rate_sel, pre_cnt);
    end
  end

endmodule : rtcct_rate_div

/* logic/rtcct_timer.sv */
// Operation
// - Reset: timer off, reload off, 32 Hz
// - Reset: all interrupt enables cleared
// - Timer runs only while run enable set
// - Two-bit field selects 32/8/1/0.5 Hz
// - Start value from bytes 18h, 19h
// - Decrement per tick; zero ends; zero loads stall
// - Nonzero start values are valid lengths
// - Auto-reload restarts period from stored value
// - Reload costs one extra tick: n+1
// - Interrupt enable lets countdown end set flag
// - Interrupt pin follows flag; host clears
// - Rate and reload writable only when stopped
// - Value bytes writable only if stopped, no reload
// - Flag holds until software writes zero
`timescale 1ns/1ps
`include "rtcct_map.svh"

module rtcct_timer #(
  parameter int unsigned BASE_DIV = `RTCCT_BASE_DIV_CYCLES
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic irq_pin_out,
  output logic irq_pin_oe
);

  logic [7:0] first_control;
  logic countdown_irq_enable;
  logic countdown_done_flag;
  logic [15:0] countdown_value;
  logic [15:0] count;
  logic source_tick;
  logic count_run_enable;
  logic auto_reload_on;
  logic source_rate_sel_lo;
  logic source_rate_sel_hi;
  logic countdown_end;
  logic wr_ctrl;
  logic wr_flags;
  logic wr_low;
  logic wr_high;
  logic flag_clear;
  rtcct_pkg::rtcct_rate_t rate_sel;
  rtcct_pkg::rtcct_state_t state;

  assign count_run_enable = first_control[`RTCCT_BIT_RUN_ENABLE];
  assign auto_reload_on = first_control[`RTCCT_BIT_AUTO_RELOAD];
  assign source_rate_sel_lo = first_control[`RTCCT_BIT_RATE_LO];
  assign source_rate_sel_hi = first_control[`RTCCT_BIT_RATE_HI];
  assign rate_sel = rtcct_pkg::rtcct_rate_t'({source_rate_sel_hi, source_rate_sel_lo});

  // Address decode
  assign wr_ctrl = reg_wr && (reg_addr == `RTCCT_ADDR_FIRST_CONTROL);
  assign wr_flags = reg_wr && (reg_addr == `RTCCT_ADDR_IRQ_FLAGS);
  assign wr_low = reg_wr && (reg_addr == `RTCCT_ADDR_VALUE_LOW);
  assign wr_high = reg_wr && (reg_addr == `RTCCT_ADDR_VALUE_HIGH);
  assign flag_clear = wr_flags && !reg_wdata[`RTCCT_BIT_DONE_FLAG];

  rtcct_rate_div #(
    .BASE_DIV(BASE_DIV)
  ) rtcct_rate_div_inst (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .rate_sel(rate_sel),
    .source_tick(source_tick)
  );

  // First control; rate and reload bits lock while running
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      first_control <= `RTCCT_FIRST_CONTROL_RESET;
    end
    else if (wr_ctrl)
    begin
      if (count_run_enable)
      begin
        // Locked fields keep their value, the rest take the write
        first_control <= (reg_wdata & 8'h9B) | (first_control & 8'h64);
      end
      else
      begin
        first_control <= reg_wdata;
      end
    end
  end

  // Interrupt enable
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      countdown_irq_enable <= `RTCCT_IRQ_CONTROL_RESET;
    end
    else if (reg_wr && (reg_addr == `RTCCT_ADDR_IRQ_CONTROL))
    begin
      countdown_irq_enable <= reg_wdata[`RTCCT_BIT_IRQ_ENABLE];
    end
  end

  // Start value bytes, writable only when stopped and not reloading
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      countdown_value <= `RTCCT_VALUE_RESET;
    end
    else if (!count_run_enable && !auto_reload_on)
    begin
      if (wr_low)
      begin
        countdown_value[7:0] <= reg_wdata;
      end
      if (wr_high)
      begin
        countdown_value[15:8] <= reg_wdata;
      end
    end
  end

  assign countdown_end = (state == rtcct_pkg::RTCCT_ST_RUN) && source_tick && (count == 16'h0001);

  // Countdown sequencer; the reload state is the extra tick between periods
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state <= rtcct_pkg::RTCCT_ST_IDLE;
      count <= 16'h0000;
    end
    else if (!count_run_enable)
    begin
      state <= rtcct_pkg::RTCCT_ST_IDLE;
    end
    else
    begin
      case (state)
        rtcct_pkg::RTCCT_ST_IDLE:
        begin
          // A zero start value never starts a countdown
          if (countdown_value != 16'h0000)
          begin
            count <= countdown_value;
            state <= rtcct_pkg::RTCCT_ST_RUN;
          end
        end
        rtcct_pkg::RTCCT_ST_RUN:
        begin
          if (source_tick)
          begin
            count <= count - 16'h0001;
            if (count == 16'h0001)
            begin
              state <= auto_reload_on ? rtcct_pkg::RTCCT_ST_RELOAD
                                      : rtcct_pkg::RTCCT_ST_DONE;
            end
          end
        end
        rtcct_pkg::RTCCT_ST_RELOAD:
        begin
          if (source_tick)
          begin
            count <= countdown_value;
            state <= rtcct_pkg::RTCCT_ST_RUN;
          end
        end
        rtcct_pkg::RTCCT_ST_DONE:
        begin
          state <= rtcct_pkg::RTCCT_ST_DONE;
        end
        default:
        begin
          state <= rtcct_pkg::RTCCT_ST_IDLE;
        end
      endcase
    end
  end

  // Sticky flag; a countdown end in the clearing cycle wins
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      countdown_done_flag <= `RTCCT_DONE_FLAG_RESET;
    end
    else if (countdown_end && countdown_irq_enable)
    begin
      countdown_done_flag <= 1'b1;
    end
    else if (flag_clear)
    begin
      countdown_done_flag <= 1'b0;
    end
  end

  // Open-drain pin: pulls low while the flag stands
  assign irq_pin_out = 1'b0;
  assign irq_pin_oe = countdown_done_flag;

  // Registered read data; unmapped addresses and unused enable and flag bits read zero, first control reads back all eight bits
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      reg_rdata <= 8'h00;
    end
    else if (reg_rd)
    begin
      case (reg_addr)
        `RTCCT_ADDR_FIRST_CONTROL: reg_rdata <= first_control;
        `RTCCT_ADDR_IRQ_CONTROL: reg_rdata <= {6'h00, countdown_irq_enable, 1'b0};
        `RTCCT_ADDR_IRQ_FLAGS: reg_rdata <= {6'h00, countdown_done_flag, 1'b0};
        `RTCCT_ADDR_VALUE_LOW: reg_rdata <= countdown_value[7:0];
        `RTCCT_ADDR_VALUE_HIGH: reg_rdata <= countdown_value[15:8];
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  sequence s_last_tick;
    (state == rtcct_pkg::RTCCT_ST_RUN) && source_tick && (count == 16'h0001) && count_run_enable;
  endsequence

  sequence s_reload_tick;
    (state == rtcct_pkg::RTCCT_ST_RELOAD) && source_tick && count_run_enable;
  endsequence

  property p_stop_idles;
    @(posedge clk_sys) disable iff (!reset_n)
    !count_run_enable |=> (state == rtcct_pkg::RTCCT_ST_IDLE);
  endproperty
  a_stop_idles: assert property (p_stop_idles) else $error("Timer not idle after stop");

  property p_reset_defaults;
    @(posedge clk_sys) disable iff (!reset_n)
    $rose(reset_n) |-> !count_run_enable && !auto_reload_on && (rate_sel == 2'h0);
  endproperty
  a_reset_defaults: assert property (p_reset_defaults) else $error("Bad control reset");

  property p_zero_stalls;
    @(posedge clk_sys) disable iff (!reset_n)
    (state == rtcct_pkg::RTCCT_ST_IDLE) && (countdown_value == 16'h0000)
      |=> (state != rtcct_pkg::RTCCT_ST_RUN);
  endproperty
  a_zero_stalls: assert property (p_zero_stalls) else $error("Zero start value ran");

  property p_reload_follows;
    @(posedge clk_sys) disable iff (!reset_n)
    s_last_tick ##1 (auto_reload_on && count_run_enable && !source_tick) [*2]
      |-> (state == rtcct_pkg::RTCCT_ST_RELOAD) && (count == 16'h0000);
  endproperty
  a_reload_follows: assert property (p_reload_follows) else $error("No reload wait");

  property p_reload_loads;
    @(posedge clk_sys) disable iff (!reset_n)
    s_reload_tick |=> (count == $past(countdown_value)) && (state == rtcct_pkg::RTCCT_ST_RUN);
  endproperty
  a_reload_loads: assert property (p_reload_loads) else $error("Reload value wrong");

  property p_flag_sets;
    @(posedge clk_sys) disable iff (!reset_n)
    countdown_end && countdown_irq_enable |=> countdown_done_flag ##0 irq_pin_oe;
  endproperty
  a_flag_sets: assert property (p_flag_sets) else $error("Flag not set at end");

  property p_flag_holds;
    @(posedge clk_sys) disable iff (!reset_n)
    countdown_done_flag && !flag_clear |=> countdown_done_flag;
  endproperty
  a_flag_holds: assert property (p_flag_holds) else $error("Flag dropped uncleared");

  property p_clear_releases;
    @(posedge clk_sys) disable iff (!reset_n)
    flag_clear && !(countdown_end && countdown_irq_enable) |=> !irq_pin_oe;
  endproperty
  a_clear_releases: assert property (p_clear_releases) else $error("Pin not released");

  property p_ctrl_lock;
    @(posedge clk_sys) disable iff (!reset_n)
    wr_ctrl && count_run_enable |=> $stable(rate_sel) && $stable(auto_reload_on);
  endproperty
  a_ctrl_lock: assert property (p_ctrl_lock) else $error("Locked control changed");

  property p_value_lock;
    @(posedge clk_sys) disable iff (!reset_n)
    (wr_low || wr_high) && (count_run_enable || auto_reload_on) |=> $stable(countdown_value);
  endproperty
  a_value_lock: assert property (p_value_lock) else $error("Locked value changed");

endmodule : rtcct_timer

/* verification/rtcct_host.sv */
`timescale 1ns/1ps
// Host side of the register port; one strobe per wr or rd call
module rtcct_host (
  input wire logic clk_sys,
  output logic reg_wr,
  output logic reg_rd,
  output logic [5:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  // Idle port from time zero
  initial
  begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 6'h3F;
    reg_wdata = 8'h00;
  end
  // Single write, held across exactly one taking edge
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #1;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clk_sys);
    #1;
    reg_wr = 1'b0;
    reg_wdata = ~d; // Released data must not look valid
  endtask : wr
  // Single read; data is registered at the taking edge
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    #1;
    reg_rd = 1'b1;
    reg_addr = a;
    @(posedge clk_sys);
    #1;
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask : rd
  // Value bytes only after run and reload are off
  task automatic load(input logic [15:0] n);
    wr(6'h00, 8'h99);
    wr(6'h18, n[7:0]);
    wr(6'h19, n[15:8]);
  endtask : load
  // Stop first, then set rate and reload, then run
  task automatic start(input logic [1:0] r, input logic rl);
    logic [7:0] c;
    c = {1'b1, r, 2'b11, rl, 1'b0, 1'b1};
    wr(6'h00, c);
    wr(6'h00, c);
    wr(6'h00, c | 8'h02);
  endtask : start
  // Release the interrupt by writing the flag to zero
  task automatic clr();
    wr(6'h02, 8'h00);
  endtask : clr
endmodule : rtcct_host

/* verification/rtcct_timer_tb_top.sv */
`timescale 1ns/1ps
module rtcct_timer_tb_top;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic reg_wr;
  logic reg_rd;
  logic [5:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic irq_pin_out;
  logic irq_pin_oe;
  logic [7:0] d;
  int fails = 0;
  int cmp_count = 0;
  int cyc = 0;
  int n;
  int t0;
  int p[4] = '{4, 16, 128, 256};
  // Short prescaler keeps the slow rates affordable
  always #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys) cyc <= cyc + 1;
  rtcct_timer #(.BASE_DIV(4)) rtcct_timer_inst (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .irq_pin_out(irq_pin_out),
    .irq_pin_oe(irq_pin_oe)
  );
  rtcct_host h (
    .clk_sys(clk_sys),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata)
  );
  // Compare and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_of_test();
    $display("fails %0d cmp_count %0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_of_test
  // Cycles until the interrupt shows, bounded
  task automatic wait_irq(output int k);
    k = 0;
    while (irq_pin_oe !== 1'b1 && k < 2000)
    begin
      @(posedge clk_sys);
      #1;
      k++;
    end
  endtask : wait_irq
  // Watchdog well beyond the longest countdown
  initial
  begin
    #200000;
    fails++;
    end_of_test();
  end
  initial
  begin
    repeat (8) @(posedge clk_sys);
    #1;
    reset_n = 1'b1;
    h.rd(6'h00, d);
    chk(d, 8'h99);
    h.rd(6'h01, d);
    chk(d, 8'h00);
    h.rd(6'h02, d);
    chk(d, 8'h00);
    h.rd(6'h05, d);
    chk(d, 8'h00);
    chk({irq_pin_oe, irq_pin_out}, 2'b00);
    h.wr(6'h01, 8'h02);
    h.load(16'h0002);
    h.rd(6'h18, d);
    chk(d, 8'h02);
    // Every rate with a two-tick countdown
    for (int r = 0; r < 4; r++)
    begin
      h.start(r[1:0], 1'b0);
      wait_irq(n);
      chk(n >= p[r] && n <= 2 * p[r] + 3, 1'b1);
      repeat (40) @(posedge clk_sys);
      chk({irq_pin_oe, irq_pin_out}, 2'b10);
      h.clr();
      chk(irq_pin_oe, 1'b0);
    end
    // Locked fields while running at the slowest rate, then value bytes while stopped with reload on
    h.wr(6'h00, 8'h9B);
    h.rd(6'h00, d);
    chk(d, 8'hFB);
    h.wr(6'h18, 8'h55);
    h.rd(6'h18, d);
    chk(d, 8'h02);
    h.wr(6'h00, 8'h9D);
    h.wr(6'h00, 8'h9D);
    h.wr(6'h18, 8'h07);
    h.rd(6'h18, d);
    chk(d, 8'h02);
    // Zero start value never ends a countdown
    h.load(16'h0000);
    h.start(2'h0, 1'b0);
    repeat (60) @(posedge clk_sys);
    chk(irq_pin_oe, 1'b0);
    // Interrupt enable off: no flag
    h.wr(6'h01, 8'h00);
    h.load(16'h0001);
    h.start(2'h0, 1'b0);
    repeat (30) @(posedge clk_sys);
    chk(irq_pin_oe, 1'b0);
    // Auto reload: n then n+1 ticks
    h.wr(6'h01, 8'h02);
    h.load(16'h0003);
    h.start(2'h0, 1'b1);
    wait_irq(n);
    chk(n >= 10 && n <= 13, 1'b1);
    t0 = cyc;
    h.clr();
    wait_irq(n);
    chk(16'(cyc - t0), 16'h0010);
    h.wr(6'h00, 8'h9D);
    h.clr();
    repeat (40) @(posedge clk_sys);
    chk(irq_pin_oe, 1'b0);
    end_of_test();
  end
endmodule : rtcct_timer_tb_top
